// file: hsb_host_ctrl.sv
// hsb_host_ctrl: host controller for the modem's serial command bus
// and its boot-select straps.
// assumes the device samples the command line on rising sclk and drives
// reply bits valid during the high phase; the reply pin is asynchronous.
`timescale 1ns/1ps
module hsb_host_ctrl
  import hsb_pkg::*;
#(
  parameter int HALF = HALF_CYC,
  parameter int SETTLE_CYCLES = WR_SETTLE_CYC,
  parameter int NB_W = 3
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,

  // transfer request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_addr,
  input wire logic cmd_write,
  input wire logic [NB_W-1:0] cmd_nbytes,

  // write data stream
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,

  // read data stream
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic xfer_done,

  // boot-select control
  input wire logic [1:0] boot_mode,
  input wire logic boot_lock,

  // device pins
  output logic host_select_n,
  output logic sclk,
  output logic cmd_line,
  input wire logic reply_line,
  output logic boot_select_high_pin,
  output logic boot_select_low_pin
);

  hsb_state_t state_r;
  logic [15:0] wait_r;
  logic [31:0] settle_r;
  logic [NB_W-1:0] left_r;
  logic [7:0] addr_r;
  logic [7:0] txb_r;
  logic write_r;
  logic eng_start_r;
  logic eng_busy;
  logic eng_done;
  logic [7:0] eng_rx;
  logic reply_s1_r;
  logic reply_s2_r;

  // reply pin comes from the device's domain: two stages before use
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reply_s1_r <= 1'b0;
      reply_s2_r <= 1'b0;
    end
    else
    begin
      reply_s1_r <= reply_line;
      reply_s2_r <= reply_s1_r;
    end
  end

  // bit engine owns the serial clock and command line
  hsb_byte_engine #(
    .HALF(HALF)
  ) u_eng (
    .clk(clk),
    .rst_b(rst_b),
    .start(eng_start_r),
    .tx_byte(txb_r),
    .busy(eng_busy),
    .done(eng_done),
    .rx_byte(eng_rx),
    .reply_sync(reply_s2_r),
    .sclk(sclk),
    .cmd_line(cmd_line)
  );

  // transaction sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= HSB_IDLE;
      wait_r <= '0;
      left_r <= '0;
      addr_r <= BYTE_RST;
      txb_r <= BYTE_RST;
      write_r <= 1'b0;
      eng_start_r <= 1'b0;
    end
    else
    begin
      eng_start_r <= 1'b0;
      case (state_r)
        HSB_IDLE:
        begin
          if (cmd_valid)
          begin
            addr_r <= cmd_addr;
            txb_r <= cmd_addr;
            write_r <= cmd_write;
            left_r <= cmd_nbytes;
            wait_r <= '0;
            state_r <= HSB_SETUP;
          end
        end
        // select falls a whole serial clock period (two half periods) before the first edge
        HSB_SETUP:
        begin
          if (wait_r == 16'(HALF - 1))
          begin
            eng_start_r <= 1'b1;
            state_r <= HSB_ADDR;
          end
          else
            wait_r <= wait_r + 16'h1;
        end
        HSB_ADDR:
        begin
          if (eng_done)
          begin
            if (left_r == '0)
              state_r <= HSB_HOLD;
            else if (write_r)
              state_r <= HSB_WAITD;
            else
            begin
              txb_r <= BYTE_RST;
              eng_start_r <= 1'b1;
              state_r <= HSB_DATA;
            end
            wait_r <= '0;
          end
        end
        // a gap between bytes is legal, so the stream may stall
        HSB_WAITD:
        begin
          if (wr_valid)
          begin
            txb_r <= wr_data;
            eng_start_r <= 1'b1;
            state_r <= HSB_DATA;
          end
        end
        HSB_DATA:
        begin
          if (eng_done)
          begin
            wait_r <= '0;
            if (left_r == NB_W'(1))
              state_r <= HSB_HOLD;
            else if (write_r)
              state_r <= HSB_WAITD;
            else
            begin
              txb_r <= BYTE_RST;
              eng_start_r <= 1'b1;
            end
            left_r <= left_r - NB_W'(1);
          end
        end
        // hold select after the last falling edge
        HSB_HOLD:
        begin
          if (wait_r == 16'(HALF - 1))
          begin
            wait_r <= '0;
            state_r <= HSB_GAP;
          end
          else
            wait_r <= wait_r + 16'h1;
        end
        // select high between transfers
        HSB_GAP:
        begin
          if (wait_r == 16'(HALF - 1))
            state_r <= write_r ? HSB_SETTLE : HSB_IDLE;
          else
            wait_r <= wait_r + 16'h1;
        end
        // the device may still be reading the last write
        HSB_SETTLE:
        begin
          if (settle_r == 32'(SETTLE_CYCLES - 1))
            state_r <= HSB_IDLE;
        end
        default: state_r <= HSB_IDLE;
      endcase
    end
  end

  // settle timer runs only in its state
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      settle_r <= '0;
    else if (state_r == HSB_SETTLE)
      settle_r <= settle_r + 32'h1;
    else
      settle_r <= '0;
  end

  // select pin: low from setup through hold
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      host_select_n <= 1'b1;
    else
      host_select_n <= !(state_r inside {HSB_SETUP, HSB_ADDR, HSB_WAITD, HSB_DATA, HSB_HOLD});
  end

  // user handshakes; all registered single-cycle pulses
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_ready <= 1'b0;
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= BYTE_RST;
      xfer_done <= 1'b0;
    end
    else
    begin
      cmd_ready <= (state_r == HSB_IDLE) && cmd_valid;
      wr_ready <= (state_r == HSB_WAITD) && wr_valid;
      rd_valid <= (state_r == HSB_DATA) && eng_done && !write_r;
      if ((state_r == HSB_DATA) && eng_done && !write_r)
        rd_data <= eng_rx;
      xfer_done <= (state_r == HSB_GAP) && (wait_r == 16'(HALF - 1));
    end
  end

  // boot straps; reserved code refused, frozen while loading runs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      boot_select_high_pin <= BOOT_RST[1];
      boot_select_low_pin <= BOOT_RST[0];
    end
    else if (!boot_lock && boot_mode != BOOT_RSVD)
    begin
      boot_select_high_pin <= boot_mode[1];
      boot_select_low_pin <= boot_mode[0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_sel_busy_low: assert property (eng_busy |-> !host_select_n)
    else $error("select high during a byte");
  a_cmd_stable_high: assert property (sclk |-> $stable(cmd_line))
    else $error("command line moved while clock high");
  a_read_cmd_quiet: assert property ((state_r == HSB_DATA && !write_r) |-> !cmd_line)
    else $error("command line active during read");
  a_addr_msb_first: assert property ((eng_start_r && state_r == HSB_ADDR) |=> cmd_line == addr_r[7])
    else $error("address not msb first");
  a_settle_len: assert property ((state_r == HSB_IDLE && $past(state_r) == HSB_SETTLE) |-> $past(settle_r) == 32'(SETTLE_CYCLES - 1))
    else $error("write settle wait wrong length");
  a_boot_frozen: assert property (boot_lock |=> $stable({boot_select_high_pin, boot_select_low_pin}))
    else $error("boot pins moved while locked");
  a_cmd_only_end: assert property ((state_r == HSB_ADDR && eng_done && left_r == '0) |=> state_r == HSB_HOLD)
    else $error("command-only transfer carried data");
  a_gap_high: assert property ((state_r == HSB_GAP) |=> host_select_n)
    else $error("select low between transfers");
  // the clock must be parked while the device is deselected
  a_clk_parked: assert property (host_select_n |-> !sclk)
    else $error("serial clock running while deselected");
  a_done_after_sel: assert property (xfer_done |-> host_select_n)
    else $error("transfer reported done with select low");
  a_no_rsvd_strap: assert property ({boot_select_high_pin, boot_select_low_pin} != BOOT_RSVD)
    else $error("reserved boot code on strap pins");

endmodule // hsb_host_ctrl

// file: hsb_pkg.sv
// hsb_pkg: constants shared by the host-side serial bus controller.
// assumes a 100 MHz system clock; the settle count derives from it and the half period is set for it.
package hsb_pkg;

  // system clock rate
  localparam int CLK_MHZ = 100;

  // serial clock half period in system cycles (5 MHz link)
  localparam int HALF_CYC = 10;

  // least wait after a write before the device has consumed it
  localparam int WR_SETTLE_US = 250;
  localparam int WR_SETTLE_CYC = WR_SETTLE_US * CLK_MHZ;

  // address values of the device register map
  localparam logic [7:0] ADR_GEN_RESET = 8'h01;
  localparam logic [7:0] ADR_CSUM_A_FIRST = 8'ha9;
  localparam logic [7:0] ADR_CSUM_A_SECOND = 8'haa;
  localparam logic [7:0] ADR_CSUM_B_FIRST = 8'hb8;
  localparam logic [7:0] ADR_CSUM_B_SECOND = 8'hb9;
  localparam logic [7:0] ADR_PROD_ID = 8'hc5;
  localparam logic [7:0] ADR_PROG_WORD = 8'hc8;
  localparam logic [7:0] ADR_IMG_VERSION = 8'hc9;

  // failed activation marker left in the first checksum register
  localparam logic [15:0] ACT_FAIL_CODE = 16'hdead;

  // boot-select codes as {high pin, low pin}
  localparam logic [1:0] BOOT_HOST = 2'h3;
  localparam logic [1:0] BOOT_RSVD = 2'h2;
  localparam logic [1:0] BOOT_MEM = 2'h1;
  localparam logic [1:0] BOOT_NONE = 2'h0;

  // values after reset
  localparam logic [1:0] BOOT_RST = BOOT_NONE;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // transaction sequencer states
  typedef enum logic [2:0] {
    HSB_IDLE,
    HSB_SETUP,
    HSB_ADDR,
    HSB_WAITD,
    HSB_DATA,
    HSB_HOLD,
    HSB_GAP,
    HSB_SETTLE
  } hsb_state_t;

endpackage

// file: hsb_byte_engine.sv
// hsb_byte_engine: shifts one byte out and one byte in on the serial link.
// assumes the reply input is already synchronised to clk.
`timescale 1ns/1ps
module hsb_byte_engine
  import hsb_pkg::*;
#(
  parameter int HALF = HALF_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // byte request
  input wire logic start,
  input wire logic [7:0] tx_byte,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte,
  // link side
  input wire logic reply_sync,
  output logic sclk,
  output logic cmd_line
);

  logic [15:0] cnt_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;

  assign rx_byte = sh_r;

  // divider and shifter; clock idles low, data changes on the fall
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      sclk <= 1'b0;
      cmd_line <= 1'b0;
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= BYTE_RST;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy <= 1'b1;
        sh_r <= tx_byte;
        cmd_line <= tx_byte[7];
        cnt_r <= '0;
        bit_r <= '0;
      end
      else if (busy)
      begin
        if (cnt_r == 16'(HALF - 1))
        begin
          cnt_r <= '0;
          if (!sclk)
            sclk <= 1'b1;
          else
          begin
            // reply sampled at the end of the high phase
            sclk <= 1'b0;
            sh_r <= {sh_r[6:0], reply_sync};
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7)
            begin
              busy <= 1'b0;
              done <= 1'b1;
              cmd_line <= 1'b0;
            end
            else
              cmd_line <= sh_r[6];
          end
        end
        else
          cnt_r <= cnt_r + 16'h1;
      end
    end
  end

endmodule // hsb_byte_engine

// file: hsb_dev_model.sv
// hsb_dev_model: behavioural stand-in for the modem device on the serial bus.
// assumes sclk idles low and the straps are steady around a reset command.
`timescale 1ns/1ps
module hsb_dev_model
  import hsb_pkg::*;
#(
  parameter logic [31:0] ACT_CODE = 32'h2b4d91e6, // arbitrary
  parameter logic [7:0] PUB = 8'h3c // arbitrary high byte of published values
)
(
  // host pins
  input wire logic host_select_n,
  input wire logic sclk,
  input wire logic cmd_line,
  input wire logic boot_select_high_pin,
  input wire logic boot_select_low_pin,
  // reply pin
  output logic reply_line
);
  int nb = 0;
  logic [7:0] sh = 8'h00;
  logic [7:0] adr = 8'h00;
  logic [31:0] code = 32'h0;
  logic pub = 1'b1;
  logic dead = 1'b0;
  logic [15:0] val;
  // write-type addresses only toggle the reply line, never drive data on it
  wire logic wr_adr = adr == ADR_PROG_WORD || adr == ADR_GEN_RESET;
  initial reply_line = 1'b0;
  // select high drops a partial byte; a released line must not keep its level
  always @(posedge host_select_n)
  begin
    nb = 0;
    reply_line = ~reply_line;
  end
  // command bits on rising clock, counted by edges only so gaps are harmless
  always @(posedge sclk)
    if (!host_select_n)
    begin
      sh = {sh[6:0], cmd_line};
      nb++;
      if (nb == 8)
        adr = sh;
      if (nb == 8 && sh == ADR_GEN_RESET && !dead && {boot_select_high_pin, boot_select_low_pin} != BOOT_RSVD)
        pub = 1'b1;
      if (nb > 8 && nb % 8 == 0 && adr == ADR_PROG_WORD && !dead)
        code = {code[23:0], sh};
      if (nb == 40 && adr == ADR_PROG_WORD && !dead)
      begin
        pub = 1'b0;
        dead = code != ACT_CODE;
      end
    end
  // reply bits change on falling clock so they stand through the high phase
  always @(negedge sclk)
    if (!host_select_n)
    begin
      val = dead && adr == ADR_CSUM_A_FIRST ? ACT_FAIL_CODE : (pub ? {PUB, adr} : 16'h0000);
      reply_line = nb >= 8 && !wr_adr ? val[15 - (nb - 8) % 16] : ~reply_line;
    end
endmodule // hsb_dev_model

// file: hsb_host_ctrl_test.sv
// hsb_host_ctrl_test: self-checking bench for the host serial controller.
// assumes hsb_dev_model answers on the device pins.
`timescale 1ns/1ps
module hsb_host_ctrl_test import hsb_pkg::*;;
  localparam int SET = 20;
  localparam logic [31:0] ACT = 32'h2b4d91e6; // arbitrary
  localparam logic [7:0] PUB = 8'h3c; // arbitrary
  logic clk, rst_b, cmd_valid, cmd_ready, cmd_write, wr_valid, wr_ready, rd_valid, xfer_done, boot_lock;
  logic host_select_n, sclk, cmd_line, reply_line, boot_select_high_pin, boot_select_low_pin, act, dead, was_wr;
  logic [7:0] cmd_addr, wr_data, rd_data;
  logic [2:0] cmd_nbytes;
  logic [1:0] boot_mode, last;
  logic [31:0] seed, rd;
  int mismatches = 0;
  int compares = 0;
  int bits = 0;
  int nrd;
  logic [7:0] rtab [6] = '{ADR_CSUM_A_FIRST, ADR_CSUM_A_SECOND, ADR_CSUM_B_FIRST, ADR_CSUM_B_SECOND, ADR_PROD_ID,
    ADR_IMG_VERSION};

  hsb_host_ctrl #(.HALF(4), .SETTLE_CYCLES(SET)) dut (.clk, .rst_b, .cmd_valid, .cmd_ready, .cmd_addr, .cmd_write,
    .cmd_nbytes, .wr_valid, .wr_data, .wr_ready, .rd_valid, .rd_data, .xfer_done, .boot_mode, .boot_lock,
    .host_select_n, .sclk, .cmd_line, .reply_line, .boot_select_high_pin, .boot_select_low_pin);
  hsb_dev_model #(.ACT_CODE(ACT), .PUB(PUB)) dev (.host_select_n, .sclk, .cmd_line, .boot_select_high_pin,
    .boot_select_low_pin, .reply_line);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // what a register should read, given activation history
  function automatic logic [15:0] exp_reg(input logic [7:0] a);
    if (dead && a == ADR_CSUM_A_FIRST)
      return ACT_FAIL_CODE;
    return act ? 16'h0000 : {PUB, a};
  endfunction

  // one whole transfer; write bytes leave msb first, read bytes gather in rd
  task automatic xfer(input logic [7:0] a, input logic w, input int n, input logic [31:0] wd);
    int i, t;
    cmd_addr = a;
    cmd_write = w;
    cmd_nbytes = 3'(n);
    cmd_valid = 1;
    i = 0;
    nrd = 0;
    rd = 0;
    wr_valid = w && n > 0;
    wr_data = 8'(wd >> (8 * (n - 1)));
    for (t = 0; t < 3000; t++)
    begin
      step(1);
      if (cmd_ready === 1'b1)
      begin
        cmd_valid = 0;
        if (was_wr && t < SET - 2)
          chk("settle", 1, 0);
      end
      if (wr_ready === 1'b1)
      begin
        i++;
        wr_valid = i < n;
        wr_data = 8'(wd >> (8 * (n - 1 - i)));
      end
      if (rd_valid === 1'b1)
      begin
        rd = {rd[23:0], rd_data};
        nrd++;
      end
      if (xfer_done === 1'b1)
        break;
    end
    if (t == 3000)
    begin
      mismatches++;
      give_verdict();
    end
    was_wr = w;
    chk("select idle", 1, host_select_n);
  endtask

  task automatic rdchk(input logic [7:0] a);
    xfer(a, 0, 2, 0);
    chk("read bytes", 2, nrd);
    chk("read value", exp_reg(a), rd);
  endtask

  // wire watch: address bits msb first, command line quiet while device replies
  always @(posedge sclk or posedge host_select_n)
    if (host_select_n)
      bits = 0;
    else
    begin
      bits++;
      if (bits <= 8)
        chk("address bit", cmd_addr[8 - bits], cmd_line);
      else if (!cmd_write)
        chk("command quiet", 0, cmd_line);
    end

  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // a hang anywhere ends the run with a failure
  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    seed = 32'hcf84;
    {cmd_valid, cmd_write, wr_valid, boot_lock, act, dead, was_wr, cmd_addr, wr_data, cmd_nbytes, boot_mode} = '0;
    rst_b = 0;
    step(5);
    rst_b = 1;
    last = BOOT_NONE;
    for (int c = 3; c >= 0; c--)
    begin
      boot_mode = 2'(c);
      step(3);
      if (2'(c) != BOOT_RSVD)
        last = 2'(c);
      chk("straps", last, {boot_select_high_pin, boot_select_low_pin});
    end
    boot_lock = 1;
    boot_mode = BOOT_MEM;
    step(3);
    chk("strap lock", BOOT_NONE, {boot_select_high_pin, boot_select_low_pin});
    $display("test straps done");
    xfer(ADR_GEN_RESET, 1, 0, 0);
    for (int r = 0; r < 10; r++)
      rdchk(rtab[$unsigned($random(seed)) % 6]);
    $display("test random reads done");
    xfer(ADR_PROG_WORD, 1, 4, ACT);
    act = 1;
    rdchk(ADR_PROD_ID);
    rdchk(ADR_CSUM_B_SECOND);
    xfer(ADR_GEN_RESET, 1, 0, 0);
    act = 0;
    rdchk(ADR_IMG_VERSION);
    $display("test activation done");
    xfer(ADR_PROG_WORD, 1, 4, ACT ^ ($random(seed) | 32'h1));
    act = 1;
    dead = 1;
    rdchk(ADR_CSUM_A_FIRST);
    xfer(ADR_GEN_RESET, 1, 0, 0);
    rdchk(ADR_CSUM_A_FIRST);
    rdchk(ADR_PROD_ID);
    $display("test bad activation done");
    give_verdict();
  end
endmodule // hsb_host_ctrl_test
